// >>> src/dap_serial_port.sv
`include "dap_consts.svh"
// ==========================================================
// two-channel converter serial port
// Operation
// - serial input captured on clock falling edge
// - third input bit selects channel of next conversion
// - low frame select starts and bounds frame
// - output bits shift on clock falling edge
// - 12-bit: zeros, id, id copy, data
// - 10-bit: same, data then two zeros
// - conversion steps paced by shift clock
module dap_serial_port #(
	parameter int unsigned RES_BITS   = `DAP_RES_BITS,
	parameter int unsigned FIFO_DEPTH = `DAP_FIFO_DEPTH
)(
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  cs_n,
	input  wire logic                  sclk,
	input  wire logic                  din,
	output logic                       dout,
	output logic                       dout_oe_n,
	input  wire logic                  sample_valid,
	input  wire logic [2*RES_BITS-1:0] sample_data,
	output logic                       sample_ready
);
	localparam logic [4:0] RES_C = 5'(RES_BITS);

	dap_stream_if #(.WIDTH(2*RES_BITS)) fill_if ();
	dap_stream_if #(.WIDTH(2*RES_BITS)) drain_if ();

	dap_pkg::dap_state_t   state_reg;
	dap_pkg::dap_state_t   state_next;
	logic [1:0]            cs_sync_reg;
	logic [2:0]            sclk_sync_reg;
	logic [1:0]            din_sync_reg;
	logic [4:0]            cnt_reg;
	logic [4:0]            cnt_next;
	logic                  chan_reg;
	logic                  chan_next;
	logic                  chan_held_reg;
	logic                  chan_held_next;
	logic [RES_BITS-1:0]   held_reg;
	logic [RES_BITS-1:0]   held_next;
	logic [RES_BITS-1:0]   sar_reg;
	logic [RES_BITS-1:0]   sar_next;
	logic [2*RES_BITS-1:0] pair_reg;
	logic [2*RES_BITS-1:0] pair_next;
	logic                  dout_reg;
	logic                  dout_next;
	logic                  oe_n_reg;
	logic                  oe_n_next;
	logic                  pop;

	// ==========================================================
	// the sample stream is buffered so the source may run ahead
	assign fill_if.valid  = sample_valid;
	assign fill_if.data   = sample_data;
	assign sample_ready   = fill_if.ready;
	assign drain_if.ready = pop;

	dap_fifo #(
		.WIDTH (2*RES_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock (clock),
		.rst   (rst),
		.fill  (fill_if.sink),
		.drain (drain_if.source)
	);

	// ==========================================================
	// pin synchronisers; stage 0 is read by stage 1 only
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cs_sync_reg   <= 2'h3;
			sclk_sync_reg <= 3'h7;
			din_sync_reg  <= 2'h0;
		end
		else
		begin
			cs_sync_reg   <= {cs_sync_reg[0], cs_n};
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
			din_sync_reg  <= {din_sync_reg[0], din};
		end
	end

	// ==========================================================
	// decoded pin events and frame position
	wire       cs_low_w    = !cs_sync_reg[1];
	wire       sclk_fall_w = sclk_sync_reg[2] && !sclk_sync_reg[1];
	wire       din_w       = din_sync_reg[1];
	wire       start_w     = (state_reg == dap_pkg::DAP_IDLE) && cs_low_w;
	wire [4:0] idx_w       = cnt_reg + 5'h01;
	wire       is_id_w     = (idx_w == `DAP_CHAN_POS) || (idx_w == `DAP_DUP_POS);
	wire       in_data_w   = (idx_w >= `DAP_DATA_POS) && (idx_w < `DAP_DATA_POS + RES_C);
	wire [4:0] step_w      = 5'(RES_C - 5'h01 - (idx_w - `DAP_DATA_POS));
	wire [RES_BITS-1:0] trial_w = sar_reg | (RES_BITS'(1) << step_w);
	wire       cmp_w       = held_reg >= trial_w;
	wire       last_w      = idx_w == `DAP_FRAME_BITS;
	// data bits outside the result field stay zero, which gives
	// the two trailing zeros of the 10-bit variant for free
	wire       bit_w       = is_id_w ? chan_held_reg : (in_data_w ? cmp_w : 1'b0);
	// fresh sample if one is buffered, else the last one again
	wire [2*RES_BITS-1:0] new_pair_w = drain_if.valid ? drain_if.data : pair_reg;

	// ==========================================================
	// frame sequencer and successive approximation
	always_comb
	begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		chan_next      = chan_reg;
		chan_held_next = chan_held_reg;
		held_next      = held_reg;
		sar_next       = sar_reg;
		pair_next      = pair_reg;
		dout_next      = dout_reg;
		oe_n_next      = oe_n_reg;
		pop            = 1'b0;
		case (state_reg)
			dap_pkg::DAP_IDLE:
			begin
				oe_n_next = 1'b1;
				if (start_w)
				begin
					// sample both inputs now, channel from control bit
					pop            = drain_if.valid;
					pair_next      = new_pair_w;
					held_next      = chan_reg ? new_pair_w[2*RES_BITS-1:RES_BITS]
						: new_pair_w[RES_BITS-1:0];
					chan_held_next = chan_reg;
					sar_next       = '0;
					cnt_next       = 5'h00;
					dout_next      = 1'b0;
					oe_n_next      = 1'b0;
					state_next     = dap_pkg::DAP_CONVERT;
				end
			end
			dap_pkg::DAP_CONVERT:
			begin
				if (!cs_low_w)
				begin
					// early select release aborts the frame
					oe_n_next  = 1'b1;
					state_next = dap_pkg::DAP_IDLE;
				end
				else if (sclk_fall_w)
				begin
					cnt_next = idx_w;
					if (cnt_reg == `DAP_DIN_CHAN_POS)
						chan_next = din_w;
					if (in_data_w && cmp_w)
						sar_next = trial_w;
					if (last_w)
					begin
						oe_n_next  = 1'b1;
						state_next = dap_pkg::DAP_DONE;
					end
					else
						dout_next = bit_w;
				end
			end
			dap_pkg::DAP_DONE:
			begin
				// wait for select to rise before a new frame
				oe_n_next = 1'b1;
				if (!cs_low_w)
					state_next = dap_pkg::DAP_IDLE;
			end
			default:
			begin
				oe_n_next  = 1'b1;
				state_next = dap_pkg::DAP_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg     <= dap_pkg::DAP_IDLE;
			cnt_reg       <= 5'h00;
			chan_reg      <= `DAP_CHAN_RESET;
			chan_held_reg <= `DAP_CHAN_RESET;
			held_reg      <= '0;
			sar_reg       <= '0;
			pair_reg      <= '0;
			dout_reg      <= 1'b0;
			oe_n_reg      <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			chan_reg      <= chan_next;
			chan_held_reg <= chan_held_next;
			held_reg      <= held_next;
			sar_reg       <= sar_next;
			pair_reg      <= pair_next;
			dout_reg      <= dout_next;
			oe_n_reg      <= oe_n_next;
		end
	end

	assign dout      = dout_reg;
	assign dout_oe_n = oe_n_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_start;
		start_w;
	endsequence

	sequence s_fall_at(logic [4:0] n);
		(state_reg == dap_pkg::DAP_CONVERT) && cs_low_w && sclk_fall_w && (cnt_reg == n);
	endsequence

	a_start_drive: assert property (s_start |=> !oe_n_reg && !dout_reg
		&& (state_reg == dap_pkg::DAP_CONVERT))
		else $error("frame start did not drive a leading zero");

	a_din_capture: assert property (s_fall_at(`DAP_DIN_CHAN_POS) |=>
		chan_reg == $past(din_w))
		else $error("channel bit not captured on third falling edge");

	a_chan_select: assert property (s_start |=> held_reg == (chan_held_reg
		? $past(new_pair_w[2*RES_BITS-1:RES_BITS]) : $past(new_pair_w[RES_BITS-1:0])))
		else $error("held sample not from selected channel");

	a_shift_fall: assert property ((state_reg == dap_pkg::DAP_CONVERT) && cs_low_w
		&& !sclk_fall_w |=> $stable(dout_reg))
		else $error("output changed without a falling edge");

	// the copy is held against the bit that went out one fall before
	a_id_pair: assert property (s_fall_at(5'h02) |=> dout_reg == $past(dout_reg)
		&& dout_reg == chan_held_reg)
		else $error("identifier and its copy differ");

	a_lead_zero: assert property (s_fall_at(5'h00) |=> !dout_reg)
		else $error("second leading bit not zero");

	a_tail_zero: assert property (s_fall_at(5'(`DAP_DATA_POS + RES_C - 5'h01))
		&& (RES_C < 5'h0c) |=> !dout_reg)
		else $error("trailing bit not zero");

	a_sar_step: assert property ((state_reg == dap_pkg::DAP_CONVERT) && !sclk_fall_w
		|=> $stable(sar_reg))
		else $error("approximation advanced without a clock edge");

	a_hold_sample: assert property ((state_reg != dap_pkg::DAP_IDLE)
		|=> $stable(held_reg))
		else $error("held sample changed during conversion");

	a_release_end: assert property (s_fall_at(5'h0f) |=> oe_n_reg
		&& (state_reg == dap_pkg::DAP_DONE))
		else $error("output not released after last bit");

	a_release_idle: assert property (!cs_low_w |=> oe_n_reg)
		else $error("output driven with select high");

	// ==========================================================
	// frame-level checks
	sequence s_cut;
		(state_reg == dap_pkg::DAP_CONVERT) && !cs_low_w;
	endsequence

	// a cut frame must leave the pin quiet at once, the host may reuse it
	a_abort_release: assert property (s_cut |=> oe_n_reg
		&& (state_reg == dap_pkg::DAP_IDLE))
		else $error("cut frame left the output driven");

	// after the last fall further falls are ignored until select rises
	a_done_hold: assert property ((state_reg == dap_pkg::DAP_DONE) && cs_low_w
		|=> (state_reg == dap_pkg::DAP_DONE) && oe_n_reg)
		else $error("finished frame restarted without select rising");

	// driving may only begin at a frame start
	a_drive_start: assert property ($fell(oe_n_reg) |-> $past(start_w))
		else $error("output enabled outside a frame start");

	// channel bit is taken on the third fall and nowhere else
	wire chan_cap_w = (state_reg == dap_pkg::DAP_CONVERT) && cs_low_w && sclk_fall_w
		&& (cnt_reg == `DAP_DIN_CHAN_POS);

	a_chan_keep: assert property (!chan_cap_w |=> $stable(chan_reg))
		else $error("channel bit changed outside the third fall");

	// after the last data fall the trial register holds the held code
	a_sar_done: assert property (s_fall_at(5'(`DAP_DATA_POS + RES_C - 5'h02))
		|=> sar_reg == held_reg)
		else $error("approximation did not settle on the held code");

	// finished state is only reached through the sixteenth fall
	a_done_count: assert property ((state_reg == dap_pkg::DAP_DONE)
		|-> cnt_reg == `DAP_FRAME_BITS)
		else $error("frame finished with a short bit count");

endmodule : dap_serial_port

// >>> src/dap_consts.svh
`ifndef DAP_CONSTS_SVH
`define DAP_CONSTS_SVH

// ==========================================================
// conversion variant and buffering
`define DAP_RES_BITS      12
`define DAP_FIFO_DEPTH    16

// ==========================================================
// output frame layout, bit positions counted from frame start
`define DAP_CHAN_POS      5'h02
`define DAP_DUP_POS       5'h03
`define DAP_DATA_POS      5'h04
`define DAP_FRAME_BITS    5'h10

// ==========================================================
// control word layout on the serial input
`define DAP_DIN_CHAN_POS  5'h02
`define DAP_CHAN_RESET    1'h0

// ==========================================================
// timing, system clock 10 MHz
`define DAP_CLK_PERIOD_NS 100
`define DAP_QUIET_NS      30
`define DAP_ACQ_NS        290
`define DAP_QUIET_CYC     ((`DAP_QUIET_NS + `DAP_CLK_PERIOD_NS - 1) / `DAP_CLK_PERIOD_NS)
`define DAP_ACQ_CYC       ((`DAP_ACQ_NS + `DAP_CLK_PERIOD_NS - 1) / `DAP_CLK_PERIOD_NS)

`endif

// >>> src/dap_pkg.sv
package dap_pkg;

	// ==========================================================
	// frame sequencer states
	typedef enum logic [1:0]
	{
		DAP_IDLE,
		DAP_CONVERT,
		DAP_DONE
	} dap_state_t;

endpackage : dap_pkg

// >>> src/dap_stream_if.sv
// ==========================================================
// valid/ready word stream between the port logic and its buffer
interface dap_stream_if #(
	parameter int unsigned WIDTH = 24
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : dap_stream_if

// >>> src/dap_fifo.sv
// ==========================================================
// sample buffer: memory plus one registered output word
module dap_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 16
)(
	input  wire logic    clock,
	input  wire logic    rst,
	dap_stream_if.sink   fill,
	dap_stream_if.source drain
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             in_ready_reg;
	logic             out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	wire              push_w;
	wire              load_w;

	// ==========================================================
	// handshakes; output stage refills from memory whenever memory holds a word and the stage is free or taken
	assign push_w      = fill.valid && in_ready_reg;
	assign load_w      = (cnt_reg != '0) && (!out_valid_reg || drain.ready);
	assign cnt_next    = cnt_reg + (AW+1)'(push_w) - (AW+1)'(load_w);
	assign fill.ready  = in_ready_reg;
	assign drain.valid = out_valid_reg;
	assign drain.data  = out_data_reg;

	// memory array carries no reset, saves area
	always_ff @(posedge clock)
	begin
		if (push_w)
			mem[wr_ptr_reg] <= fill.data;
		if (load_w)
			out_data_reg <= mem[rd_ptr_reg];
	end

	// pointers, fill count and registered flags
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			cnt_reg       <= '0;
			in_ready_reg  <= 1'b0;
			out_valid_reg <= 1'b0;
		end
		else
		begin
			wr_ptr_reg    <= push_w ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
			rd_ptr_reg    <= load_w ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
			cnt_reg       <= cnt_next;
			in_ready_reg  <= cnt_next < DEPTH_C;
			out_valid_reg <= load_w || (out_valid_reg && !drain.ready);
		end
	end
endmodule : dap_fifo

// >>> tb/dap_host_model.sv
// ==========================================================
// serial master standing in for the host processor
module dap_host_model
(
	input  wire logic clock,
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout_w,
	input  wire logic dout_s_w
);
	timeunit 1ns;
	timeprecision 1ps;

	// select and clock idle high, din low; shift clock still outside frames
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din  = 1'b0;
	end

	// one frame; nfall below 16 aborts it early
	// phases of four clocks keep the synchronisers happy
	task automatic run_frame(input logic nxt, input int nfall, output logic [15:0] got,
		output logic [15:0] got_s);
		got   = 16'h0000;
		got_s = 16'h0000;
		@(negedge clock);
		din  <= 1'($urandom);
		cs_n <= 1'b0;
		repeat (6) @(negedge clock);
		got[15]   = dout_w;
		got_s[15] = dout_s_w;
		for (int k = 1; k <= nfall; k++)
		begin
			sclk <= 1'b0;
			repeat (4) @(negedge clock);
			sclk <= 1'b1;
			// din settles a whole phase before the next fall
			din  <= (k == 2) ? nxt : 1'($urandom);
			repeat (4) @(negedge clock);
			if (k < 16)
			begin
				got[15-k]   = dout_w;
				got_s[15-k] = dout_s_w;
			end
		end
		cs_n <= 1'b1;
		// gap covers quiet time and acquisition
		repeat (8) @(negedge clock);
	endtask : run_frame
endmodule : dap_host_model

// >>> tb/tb_top.sv
// ==========================================================
// top bench with reference model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock;
	logic        rst;
	logic        cs_n;
	logic        sclk;
	logic        din;
	logic        dout;
	logic        dout_oe_n;
	logic        sample_valid;
	logic [23:0] sample_data;
	logic        sample_ready;
	wire         dout_w;
	logic        dout_s;
	logic        dout_oe_s_n;
	logic        sample_ready_s;
	wire         dout_s_w;
	int          err_count;
	int          n_tests;
	logic [23:0] q[$];
	logic [23:0] cur;
	logic        ch_m;

	// released output floats so a stray bit never matches
	assign dout_w   = dout_oe_n ? 1'bz : dout;
	assign dout_s_w = dout_oe_s_n ? 1'bz : dout_s;

	dap_serial_port #(.RES_BITS(12), .FIFO_DEPTH(16)) dut_u
	(
		.clock        (clock),
		.rst          (rst),
		.cs_n         (cs_n),
		.sclk         (sclk),
		.din          (din),
		.dout         (dout),
		.dout_oe_n    (dout_oe_n),
		.sample_valid (sample_valid),
		.sample_data  (sample_data),
		.sample_ready (sample_ready)
	);

	// 10-bit variant on the same pins, fed the low ten bits of each code
	dap_serial_port #(.RES_BITS(10), .FIFO_DEPTH(16)) dut_short_u
	(
		.clock        (clock),
		.rst          (rst),
		.cs_n         (cs_n),
		.sclk         (sclk),
		.din          (din),
		.dout         (dout_s),
		.dout_oe_n    (dout_oe_s_n),
		.sample_valid (sample_valid),
		.sample_data  ({sample_data[21:12], sample_data[9:0]}),
		.sample_ready (sample_ready_s)
	);

	dap_host_model host_u
	(
		.clock  (clock),
		.cs_n   (cs_n),
		.sclk   (sclk),
		.din    (din),
		.dout_w   (dout_w),
		.dout_s_w (dout_s_w)
	);

	// ==========================================================
	// checking and verdict
	task automatic chk_frame(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_frame

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// stimulus
	// data held while refused, new word only after a take
	task automatic push(input int n, output int t);
		logic tk;
		t = 0;
		@(negedge clock);
		sample_valid <= 1'b1;
		sample_data  <= 24'($urandom);
		for (int i = 0; i < 40 && t < n; i++)
		begin
			// ready is settled here and stands through the next rising edge
			tk = (sample_ready === 1'b1);
			@(posedge clock);
			if (tk)
			begin
				q.push_back(sample_data);
				t++;
			end
			@(negedge clock);
			if (tk)
				sample_data <= 24'($urandom);
		end
		sample_valid <= 1'b0;
	endtask : push

	// expected frame; an empty buffer reuses the last pair
	function automatic logic [15:0] expect_frame();
		if (q.size() > 0)
			cur = q.pop_front();
		return {2'b00, ch_m, ch_m, ch_m ? cur[23:12] : cur[11:0]};
	endfunction : expect_frame

	// 10-bit frame from the same pair: ten code bits, two trailing zeros
	function automatic logic [15:0] expect_short();
		return {2'b00, ch_m, ch_m, ch_m ? cur[21:12] : cur[9:0], 2'b00};
	endfunction : expect_short

	always #50 clock = ~clock;

	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		report_and_stop();
	end

	initial
	begin
		int          t;
		int          nf;
		logic        nxt;
		logic [15:0] e;
		logic [15:0] g;
		logic [15:0] m;
		logic [15:0] es;
		logic [15:0] gs;
		clock        = 1'b0;
		rst          = 1'b1;
		sample_valid = 1'b0;
		sample_data  = 24'h000000;
		err_count    = 0;
		n_tests      = 0;
		ch_m         = 1'b0;
		cur          = 24'h000000;
		void'($urandom(32'h7917));
		repeat (20) @(negedge clock);
		rst = 1'b0;
		repeat (5) @(negedge clock);
		// fill until refused: 16 memory words plus output stage
		push(20, t);
		chk_frame("taken", 16'd17, t[15:0]);
		chk_bit("ready_full", 1'b0, sample_ready);
		chk_bit("ready_full_short", 1'b0, sample_ready_s);
		// drain past empty; frame 5 is aborted after two falls
		for (int i = 0; i < 20; i++)
		begin
			nxt = 1'($urandom);
			nf  = (i == 5) ? 2 : 16;
			m   = (nf == 16) ? 16'hffff : 16'he000;
			e   = expect_frame();
			es  = expect_short();
			host_u.run_frame(nxt, nf, g, gs);
			chk_frame("frame", e & m, g & m);
			chk_frame("frame_short", es & m, gs & m);
			chk_bit("released", 1'b1, dout_oe_n);
			chk_bit("released_short", 1'b1, dout_oe_s_n);
			if (nf == 16)
				ch_m = nxt;
		end
		chk_bit("ready_empty", 1'b1, sample_ready);
		chk_bit("ready_empty_short", 1'b1, sample_ready_s);
		report_and_stop();
	end
endmodule : tb_top
